// *** design/host_serial_and_loopback_ctrl.sv ***
// Purpose: Serial host port, loopback selection, hardware-mode pin reuse and interrupt pin
// Assumes: All pins are asynchronous to clk and pass two flip-flops; sclk at most clk/8
// Notes: Avalon-MM slave with one wait state; command registers live on the serial side
// Operation
// - In hardware mode the loopback mode follows the remote and local loop inputs as {remote, local}.
// - In host mode both loop inputs are ignored and the loopback mode comes from the channel control register.
// - The serial port answers only while the active-low chip select is low.
// - Serial input bits are sampled on rising edges of the serial clock.
// - During reads the serial output changes only on falling edges of the serial clock.
// - A read shifts out, MSB first, the addressed command register.
// - The serial output is driven only during the data phase of a read and released once it completes.
// - While the register reset input is low all command registers return to their defaults.
// - In host mode a pending interrupt drives the interrupt pin low.
// - With the interrupt enable bit cleared the interrupt pin stays high.
// - In hardware mode select, serial clock, data in, data out and interrupt pins act as control inputs.
`timescale 1ns/1ps
module host_serial_and_loopback_ctrl
	import serial_ctrl_pkg::*;
(
	input wire logic clk,
	input wire logic srst,
	input wire logic [serial_ctrl_pkg::AV_ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic irq,
	input wire logic host_mode_pin,
	input wire serial_ctrl_pkg::serial_in_t serial_pins,
	input wire logic sdo_i,
	output logic sdo_o,
	output logic sdo_oe,
	input wire logic int_i,
	output logic int_o,
	output logic int_oe,
	input wire logic reg_reset_n,
	input wire logic local_loop_select,
	input wire logic remote_loop_select,
	input wire logic [serial_ctrl_pkg::ALARM_W-1:0] line_alarm,
	output serial_ctrl_pkg::loop_mode_t loop_mode,
	output serial_ctrl_pkg::hw_ctrl_t hw_ctrl
);
	import serial_ctrl_pkg::*;

	logic [SYNC_W-1:0] sync1_q, sync2_q;
	logic hm_s, cs_n_s, sclk_s, sdi_s, sdo_in_s, int_in_s, rst_n_s, local_loop_s, remote_loop_s;
	logic [ALARM_W-1:0] alarm_s, alarm_prev_q;
	logic sclk_prev_q;
	logic sclk_rise, sclk_fall, active;
	sp_state_t state_q, state_d;
	logic [CNT_W-1:0] cnt_q, cnt_d;
	logic [CMD_W-1:0] shin_q, shin_d, shout_q, shout_d;
	logic [ADDR_W-1:0] addr_q, addr_d;
	logic rd_q, rd_d, sdo_q, sdo_d, oe_q, oe_d;
	logic wr_commit, rd_load, rd_done;
	logic [CMD_W-1:0] cmd_q [CMD_COUNT];
	logic [ADDR_W-1:0] hdr_addr;
	logic hdr_rw, hdr_hit, wr_hit;
	logic [CMD_W-1:0] shift_word, cmd_sel;
	logic stat_rd_clr, int_en, pending, pending_q;
	logic [ALARM_W-1:0] alarm_rise;
	loop_mode_t host_loop, loop_d;
	hw_ctrl_t hw_d;
	logic int_o_q, int_oe_q;
	logic ack_q;
	logic [31:0] ctrl_q, rdata_q, rd_mux;
	logic [EV_W-1:0] status_q, mask_q, events;
	logic req, port_en, status_clr, mask_wr, ctrl_wr;

	// Every pin is two-stage synchronised; only sync2_q is read by logic
	always_ff @(posedge clk) begin
		if (srst) begin
			sync1_q <= SYNC_INIT;
			sync2_q <= SYNC_INIT;
		end else begin
			sync1_q <= {host_mode_pin, serial_pins.cs_n, serial_pins.sclk, serial_pins.serial_port_in, sdo_i, int_i,
				reg_reset_n, local_loop_select, remote_loop_select, line_alarm};
			sync2_q <= sync1_q;
		end
	end

	assign {hm_s, cs_n_s, sclk_s, sdi_s, sdo_in_s, int_in_s, rst_n_s, local_loop_s, remote_loop_s, alarm_s} = sync2_q;

	always_ff @(posedge clk) begin
		if (srst) begin
			sclk_prev_q <= 1'b0;
			alarm_prev_q <= '0;
		end else begin
			sclk_prev_q <= sclk_s;
			alarm_prev_q <= alarm_s;
		end
	end

	assign sclk_rise = sclk_s & ~sclk_prev_q;
	assign sclk_fall = ~sclk_s & sclk_prev_q;
	assign alarm_rise = alarm_s & ~alarm_prev_q;
	// Deselect mid-frame aborts the access and drops any write in flight
	assign active = hm_s & ~cs_n_s & port_en;

	assign shift_word = {shin_q[CMD_W-2:0], sdi_s};
	assign hdr_rw = shin_q[HDR_RW_POS];
	assign hdr_addr = shift_word[ADDR_W-1:0];
	assign hdr_hit = (hdr_addr[ADDR_W-1:CMD_IDX_W] == '0);
	assign cmd_sel = hdr_hit ? cmd_q[hdr_addr[CMD_IDX_W-1:0]] : CMD_RESET_VAL;
	assign wr_hit = (addr_q[ADDR_W-1:CMD_IDX_W] == '0) && (addr_q[CMD_IDX_W-1:0] != CMD_ALARM_STAT);

	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		shin_d = shin_q;
		shout_d = shout_q;
		addr_d = addr_q;
		rd_d = rd_q;
		sdo_d = sdo_q;
		oe_d = oe_q;
		wr_commit = 1'b0;
		rd_load = 1'b0;
		rd_done = 1'b0;
		unique case (state_q)
			SP_IDLE: begin
				if (active) begin
					state_d = SP_HDR;
					cnt_d = '0;
				end
			end
			SP_HDR: begin
				if (sclk_rise) begin
					shin_d = shift_word;
					cnt_d = cnt_q + 3'h1;
					if (cnt_q == HDR_LAST) begin
						rd_d = hdr_rw;
						addr_d = hdr_addr;
						rd_load = hdr_rw;
						shout_d = cmd_sel;
						state_d = SP_DATA;
					end
				end
			end
			SP_DATA: begin
				if (sclk_fall && rd_q) begin
					sdo_d = shout_q[CMD_W-1];
					shout_d = {shout_q[CMD_W-2:0], 1'b0};
					oe_d = 1'b1;
				end
				if (sclk_rise) begin
					shin_d = shift_word;
					cnt_d = cnt_q + 3'h1;
					if (cnt_q == DATA_LAST) begin
						state_d = SP_END;
						oe_d = 1'b0;
						wr_commit = ~rd_q;
						rd_done = rd_q;
					end
				end
			end
			SP_END: begin
				state_d = SP_END;
			end
		endcase
		if (!active) begin
			state_d = SP_IDLE;
			oe_d = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			state_q <= SP_IDLE;
			cnt_q <= '0;
			shin_q <= '0;
			shout_q <= '0;
			addr_q <= '0;
			rd_q <= 1'b0;
			sdo_q <= 1'b0;
			oe_q <= 1'b0;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			shin_q <= shin_d;
			shout_q <= shout_d;
			addr_q <= addr_d;
			rd_q <= rd_d;
			sdo_q <= sdo_d;
			oe_q <= oe_d;
		end
	end

	assign sdo_o = sdo_q;
	assign sdo_oe = oe_q;

	// Reading the alarm register clears it; a new alarm in the same cycle still lands
	assign stat_rd_clr = rd_load && hdr_hit && (hdr_addr[CMD_IDX_W-1:0] == CMD_ALARM_STAT);

	always_ff @(posedge clk) begin
		if (srst || !rst_n_s) begin
			for (int i = 0; i < CMD_COUNT; i++) begin
				cmd_q[i] <= CMD_RESET_VAL;
			end
		end else begin
			if (wr_commit && wr_hit) begin
				cmd_q[addr_q[CMD_IDX_W-1:0]] <= shift_word;
			end
			cmd_q[CMD_ALARM_STAT] <= (cmd_q[CMD_ALARM_STAT] & ~{CMD_W{stat_rd_clr}}) | CMD_W'(alarm_rise);
		end
	end

	assign int_en = cmd_q[CMD_CHAN_CTRL][CHAN_INT_EN_BIT];
	assign pending = int_en & (|cmd_q[CMD_ALARM_STAT]);
	assign host_loop = loop_mode_t'(cmd_q[CMD_CHAN_CTRL][CHAN_LOOP_LSB +: 2]);
	assign loop_d = hm_s ? host_loop : loop_mode_t'({remote_loop_s, local_loop_s});
	// Pins double as control inputs only outside host mode; they read zero otherwise
	assign hw_d = hm_s ? '0 : hw_ctrl_t'({cs_n_s, sclk_s, sdi_s, sdo_in_s, int_in_s});

	always_ff @(posedge clk) begin
		if (srst) begin
			loop_mode <= LOOP_NORMAL;
			hw_ctrl <= '0;
			int_o_q <= 1'b1;
			int_oe_q <= 1'b0;
			pending_q <= 1'b0;
		end else begin
			loop_mode <= loop_d;
			hw_ctrl <= hw_d;
			int_o_q <= ~(pending & hm_s);
			int_oe_q <= hm_s;
			pending_q <= pending & hm_s;
		end
	end

	assign int_o = int_o_q;
	assign int_oe = int_oe_q;

	// Avalon slave: every access takes exactly one wait state
	assign req = avs_read | avs_write;
	assign avs_waitrequest = req & ~ack_q;
	assign status_clr = avs_read & ack_q & (avs_address == AV_STATUS);
	assign mask_wr = avs_write & ack_q & (avs_address == AV_MASK);
	assign ctrl_wr = avs_write & ack_q & (avs_address == AV_CTRL);
	assign port_en = ctrl_q[CTRL_PORT_EN_BIT];
	assign events = {~pending_q & pending & hm_s, rd_done, wr_commit};
	assign rd_mux = (avs_address == AV_STATUS) ? 32'(status_q) :
		(avs_address == AV_MASK) ? 32'(mask_q) :
		(avs_address == AV_MODE) ? 32'({hm_s, state_q, loop_mode}) :
		(avs_address == AV_CTRL) ? ctrl_q : 32'h0000_0000;

	always_ff @(posedge clk) begin
		if (srst) begin
			ack_q <= 1'b0;
			rdata_q <= '0;
			status_q <= '0;
			mask_q <= MASK_RESET;
			ctrl_q <= CTRL_RESET;
		end else begin
			ack_q <= req & ~ack_q;
			if (avs_read && !ack_q) begin
				rdata_q <= rd_mux;
			end
			status_q <= (status_q & ~{EV_W{status_clr}}) | events;
			if (mask_wr) begin
				mask_q <= avs_writedata[EV_W-1:0];
			end
			if (ctrl_wr) begin
				ctrl_q <= avs_writedata;
			end
		end
	end

	assign avs_readdata = rdata_q;
	assign irq = |(status_q & mask_q);

	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	chk_hw_loop_map: assert property (!hm_s |=> loop_mode == loop_mode_t'($past({remote_loop_s, local_loop_s})))
		else $error("hardware loop mode mismatch");
	chk_host_loop_ignore: assert property (hm_s && $stable(host_loop) |=> loop_mode == $past(host_loop))
		else $error("host loop mode not from register");
	chk_cs_idle_state: assert property (cs_n_s |=> state_q == SP_IDLE && !sdo_oe)
		else $error("serial port active while deselected");
	// A disabled port must drop any frame at once, even with select low
	chk_port_off_idle: assert property (!port_en |=> state_q == SP_IDLE && !sdo_oe)
		else $error("serial port active while disabled");
	chk_sample_on_rise: assert property ((state_q == SP_HDR) && sclk_rise |=> shin_q[0] == $past(sdi_s))
		else $error("input bit not sampled at rise");
	chk_sdo_on_fall: assert property (!$stable(sdo_q) |-> $past(sclk_fall))
		else $error("serial output moved off a falling edge");
	chk_read_load_word: assert property (rd_load |=> shout_q == $past(cmd_sel) && state_q == SP_DATA)
		else $error("read word not loaded");
	chk_sdo_release_end: assert property (state_q inside {SP_IDLE, SP_HDR, SP_END} |-> !sdo_oe)
		else $error("serial output driven outside read data");
	chk_reg_reset_default: assert property (!rst_n_s |=> cmd_q[CMD_CHAN_CTRL] == CMD_RESET_VAL && !int_en)
		else $error("register reset ignored");
	chk_int_pin_low: assert property (hm_s && pending |=> !int_o && int_oe)
		else $error("pending interrupt not signalled");
	chk_int_disable: assert property (!int_en |=> int_o)
		else $error("interrupt signalled while disabled");
	// Output enables lag the mode by one register, so they are checked one cycle on, not two
	chk_hw_pin_reuse: assert property (!hm_s |=> hw_ctrl == $past(hw_d) && !sdo_oe && !int_oe)
		else $error("hardware pin reuse mismatch");
endmodule // host_serial_and_loopback_ctrl

// *** design/serial_ctrl_pkg.sv ***
// Purpose: Shared constants and types for the host serial and loopback control block
// Assumes: 40 MHz system clock; serial clock well below a quarter of it
// Notes: Frame is an 8-bit header (read flag, 7-bit address) then 8 data bits, MSB first
package serial_ctrl_pkg;
	localparam int CMD_W = 8;
	localparam int CMD_COUNT = 8;
	localparam int CMD_IDX_W = 3;
	localparam int ADDR_W = 7;
	localparam int CNT_W = 3;
	localparam int ALARM_W = 2;
	localparam int SYNC_W = 11;
	localparam int HDR_RW_POS = 6;
	localparam int CHAN_INT_EN_BIT = 0;
	localparam int CHAN_LOOP_LSB = 1;
	localparam logic [CNT_W-1:0] HDR_LAST = 3'h7;
	localparam logic [CNT_W-1:0] DATA_LAST = 3'h7;
	localparam logic [CMD_IDX_W-1:0] CMD_CHAN_CTRL = 3'h0;
	localparam logic [CMD_IDX_W-1:0] CMD_ALARM_STAT = 3'h1;
	localparam logic [CMD_W-1:0] CMD_RESET_VAL = 8'h00;
	// Sync vector order: host_mode, cs_n, sclk, sdi, sdo_i, int_i, reg_reset_n, local loop, remote loop, alarm[1:0]
	localparam logic [SYNC_W-1:0] SYNC_INIT = 11'h210;
	localparam int AV_ADDR_W = 4;
	localparam logic [AV_ADDR_W-1:0] AV_STATUS = 4'h0;
	localparam logic [AV_ADDR_W-1:0] AV_MASK = 4'h4;
	localparam logic [AV_ADDR_W-1:0] AV_MODE = 4'h8;
	localparam logic [AV_ADDR_W-1:0] AV_CTRL = 4'hc;
	localparam int EV_W = 3;
	localparam int EV_WRITE = 0;
	localparam int EV_READ = 1;
	localparam int EV_INT = 2;
	localparam int CTRL_PORT_EN_BIT = 0;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
	localparam logic [EV_W-1:0] MASK_RESET = 3'h0;

	typedef enum logic [1:0] {
		LOOP_NORMAL = 2'b00,
		LOOP_ANALOG_LOCAL = 2'b01,
		LOOP_REMOTE = 2'b10,
		LOOP_DIGITAL = 2'b11
	} loop_mode_t;

	typedef enum logic [1:0] {
		SP_IDLE = 2'b00,
		SP_HDR = 2'b01,
		SP_DATA = 2'b10,
		SP_END = 2'b11
	} sp_state_t;

	typedef struct packed {
		logic cs_n;
		logic sclk;
		logic serial_port_in;
	} serial_in_t;

	typedef struct packed {
		logic receive_clock_invert;
		logic transmit_clock_invert;
		logic receiver_power_on;
		logic receive_monitor_mode;
		logic mute_on_signal_loss;
	} hw_ctrl_t;
endpackage

// *** dv/host_serial_and_loopback_ctrl_tb_top.sv ***
// Purpose: Self-checking bench for the serial host port and loopback control
// Assumes: Host model on the serial pins, bench as Avalon master
// Notes: Pin-derived outputs are checked six clocks after a change
`timescale 1ns/1ps
module host_serial_and_loopback_ctrl_tb_top;
	import serial_ctrl_pkg::*;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic [AV_ADDR_W-1:0] avs_address = 4'h0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest, irq, sdo_o, sdo_oe, int_o, int_oe;
	logic host_mode_pin = 1'b0;
	logic sdo_i = 1'b0;
	logic int_i = 1'b0;
	logic reg_reset_n = 1'b1;
	logic local_loop_select = 1'b0;
	logic remote_loop_select = 1'b0;
	logic [ALARM_W-1:0] line_alarm = 2'h0;
	serial_in_t pins;
	loop_mode_t loop_mode;
	hw_ctrl_t hw_ctrl;
	int mismatches = 0;
	int total_checks = 0;
	always #12.5 clk = ~clk;
	serial_host_model serial_host_model_i (.clk(clk), .sdo_o(sdo_o), .sdo_oe(sdo_oe), .pins(pins));
	host_serial_and_loopback_ctrl host_serial_and_loopback_ctrl_i (.clk(clk), .srst(srst),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq), .host_mode_pin(host_mode_pin),
		.serial_pins(pins), .sdo_i(sdo_i), .sdo_o(sdo_o), .sdo_oe(sdo_oe), .int_i(int_i), .int_o(int_o),
		.int_oe(int_oe), .reg_reset_n(reg_reset_n), .local_loop_select(local_loop_select),
		.remote_loop_select(remote_loop_select),
		.line_alarm(line_alarm), .loop_mode(loop_mode), .hw_ctrl(hw_ctrl));
	function automatic loop_mode_t exp_loop(input logic r, input logic l);
		return loop_mode_t'({r, l});
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks=%0d mismatches=%0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic avm(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk);
		avs_address <= a;
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= d;
		do begin
			@(posedge clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 50);
		if (n >= 50) begin
			mismatches++;
			tally_and_finish();
		end
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	initial begin
		logic [31:0] q;
		logic [7:0] s, d, r0;
		logic [4:0] v;
		void'($urandom(29038));
		repeat (5) @(posedge clk);
		srst <= 1'b0;
		for (int m = 0; m < 4; m++) begin
			v = 5'($urandom);
			@(posedge clk);
			remote_loop_select <= m[1];
			local_loop_select <= m[0];
			sdo_i <= v[1];
			int_i <= v[0];
			serial_host_model_i.set_pins(v[4:2]);
			repeat (6) @(posedge clk);
			check(loop_mode, exp_loop(m[1], m[0]));
			check(hw_ctrl, v);
		end
		serial_host_model_i.set_pins(3'b100);
		host_mode_pin <= 1'b1;
		repeat (6) @(posedge clk);
		check(hw_ctrl, 32'h0);
		avm(1'b0, AV_CTRL, 32'h0, q);
		check(q, CTRL_RESET);
		avm(1'b0, 4'h2, 32'h0, q);
		check(q, 32'h0);
		avm(1'b1, AV_MASK, 32'h4, q);
		for (int a = 0; a < 8; a++) begin
			if (a == 1) continue;
			d = 8'($urandom);
			if (a == 0) d[0] = 1'b0;
			if (a == 0) r0 = d;
			@(posedge clk);
			remote_loop_select <= 1'($urandom);
			local_loop_select <= 1'($urandom);
			serial_host_model_i.frame(1'b0, 7'(a), d, 16, s);
			check(sdo_oe, 1'b0);
			serial_host_model_i.frame(1'b1, 7'(a), 8'h00, 16, s);
			check(s, d);
			check(sdo_oe, 1'b0);
			if (a == 0) check(loop_mode, d[2:1]);
		end
		serial_host_model_i.frame(1'b1, 7'h08, 8'h00, 16, s);
		check(s, 8'h00);
		serial_host_model_i.frame(1'b0, 7'h00, ~r0, 12, s);
		serial_host_model_i.frame(1'b1, 7'h00, 8'h00, 16, s);
		check(s, r0);
		avm(1'b1, AV_CTRL, 32'h0, q);
		serial_host_model_i.frame(1'b0, 7'h00, ~r0, 16, s);
		avm(1'b1, AV_CTRL, CTRL_RESET, q);
		serial_host_model_i.frame(1'b1, 7'h00, 8'h00, 16, s);
		check(s, r0);
		line_alarm <= 2'b10;
		repeat (8) @(posedge clk);
		check(int_o, 1'b1);
		serial_host_model_i.frame(1'b0, 7'h00, 8'h07, 16, s);
		check(int_o, 1'b0);
		check(int_oe, 1'b1);
		check(irq, 1'b1);
		avm(1'b0, AV_STATUS, 32'h0, q);
		check(q[2], 1'b1);
		repeat (2) @(posedge clk);
		check(irq, 1'b0);
		serial_host_model_i.frame(1'b1, 7'h01, 8'h00, 16, s);
		check(s, 8'h02);
		check(int_o, 1'b1);
		check(loop_mode, LOOP_DIGITAL);
		line_alarm <= 2'b00;
		reg_reset_n <= 1'b0;
		repeat (6) @(posedge clk);
		reg_reset_n <= 1'b1;
		repeat (4) @(posedge clk);
		serial_host_model_i.frame(1'b1, 7'h00, 8'h00, 16, s);
		check(s, CMD_RESET_VAL);
		check(loop_mode, LOOP_NORMAL);
		serial_host_model_i.frame(1'b1, 7'h07, 8'h00, 16, s);
		check(s, CMD_RESET_VAL);
		avm(1'b0, AV_MODE, 32'h0, q);
		check(q, 32'({1'b1, SP_IDLE, LOOP_NORMAL}));
		tally_and_finish();
	end
	initial begin
		repeat (20000) @(posedge clk);
		mismatches++;
		tally_and_finish();
	end
endmodule // host_serial_and_loopback_ctrl_tb_top

// *** dv/serial_host_model.sv ***
// Purpose: Host side of the serial control port, driving select, clock and data
// Assumes: sclk idles low between frames, 8 clk per sclk period
// Notes: sdi goes low when released, as the pin is pulled down
`timescale 1ns/1ps
module serial_host_model (
	input wire logic clk,
	input wire logic sdo_o,
	input wire logic sdo_oe,
	output serial_ctrl_pkg::serial_in_t pins
);
	import serial_ctrl_pkg::*;
	initial pins = 3'b100;
	task automatic wait4();
		repeat (4) @(posedge clk);
	endtask
	// Stop below 16 aborts the frame early by raising select
	task automatic frame(input logic rd, input logic [6:0] a, input logic [7:0] d, input int stop,
		output logic [7:0] q);
		logic [15:0] w;
		w = {rd, a, d};
		q = 8'h00;
		@(posedge clk);
		pins.cs_n <= 1'b0;
		for (int i = 0; i < stop; i++) begin
			pins.serial_port_in <= w[15-i];
			wait4();
			// A released output has no pull, so it reads as the inverse of its last bit
			if (i > 7) q = {q[6:0], (sdo_oe === 1'b1) ? sdo_o : ~sdo_o};
			pins.sclk <= 1'b1;
			wait4();
			pins.sclk <= 1'b0;
		end
		wait4();
		pins <= 3'b100;
		repeat (8) @(posedge clk);
	endtask
	task automatic set_pins(input serial_in_t v);
		@(posedge clk);
		pins <= v;
	endtask
endmodule // serial_host_model
